// *** mfca_defines.svh ***
/*
  constants of the multi-function channel arbiter: control and status
  bit positions, selection codes, table lengths, reset values.
  assumes inclusion by bare name from the package and the modules.
*/
`ifndef MFCA_DEFINES_SVH
`define MFCA_DEFINES_SVH
`define MFCA_STS_TABLE_BIT   0
`define MFCA_STS_NEG_BIT     1
`define MFCA_CTL_LOAD_BIT    16
`define MFCA_CTL_SEL_HI      19
`define MFCA_CTL_SEL_LO      17
`define MFCA_CTL_ON_BIT      31
`define MFCA_SEL_WRR32       3'h1
`define MFCA_SEL_WRR64       3'h2
`define MFCA_SEL_WRR128      3'h3
`define MFCA_SEL_TWRR128     3'h4
`define MFCA_SEL_TWRR256     3'h5
`define MFCA_LEN_32          9'h020
`define MFCA_LEN_64          9'h040
`define MFCA_LEN_128         9'h080
`define MFCA_LEN_256         9'h100
`define MFCA_STS_WIDTH       16
`define MFCA_STS_RESET       16'h0000
`define MFCA_ONE_PTR         8'h01
`define MFCA_ZERO_PTR        8'h00
`endif

// *** mfca_pkg.sv ***
/*
  types of the multi-function channel arbiter.
  assumes mfca_defines.svh is on the include path.
*/
`include "mfca_defines.svh"
package mfca_pkg;
  typedef enum logic [3:0] {
    MFCA_IDLE  = 4'h1,
    MFCA_LOOK  = 4'h2,
    MFCA_GRANT = 4'h4,
    MFCA_LOAD  = 4'h8
  } mfca_state_t;
  typedef logic [2:0] mfca_sel_t;
endpackage

// *** mfca_table_if.sv ***
/*
  carrier between the arbiter top and its table store: write port,
  load request and the working-copy read port.
  assumes a single clock shared by both ends.
*/
`timescale 1ns/10ps
interface mfca_table_if #(parameter int ENTRY_W = 4, parameter int PTR_W = 8);
  logic               wr_en;
  logic [PTR_W-1:0]   wr_addr;
  logic [ENTRY_W-1:0] wr_data;
  logic               load_start;
  logic               load_done;
  logic [PTR_W-1:0]   rd_addr;
  logic [ENTRY_W-1:0] rd_data;
  modport arb (output wr_en, wr_addr, wr_data, load_start, rd_addr,
               input  load_done, rd_data);
  modport store (input wr_en, wr_addr, wr_data, load_start, rd_addr,
                 output load_done, rd_data);
endinterface

// *** mfca_table.sv ***
/*
  table store: software-written shadow table and the working copy that
  arbitration reads. a load copies shadow to working, one entry a cycle.
  assumes reset contents give every function a phase (round robin).
*/
`timescale 1ns/10ps
module mfca_table #(
  parameter int ENTRY_W = 4,
  parameter int PTR_W   = 8,
  parameter int DEPTH   = 256,
  parameter int N_FUNC  = 8
) (
  input  wire logic    clk_i,
  input  wire logic    rstn_i,
  input  wire logic    ce_i,
  mfca_table_if.store  tb
);
  import mfca_pkg::*;
  logic [ENTRY_W-1:0] shadow  [DEPTH];
  logic [ENTRY_W-1:0] working [DEPTH];
  logic               busy;
  logic               next_busy;
  logic [PTR_W:0]     cnt;
  logic [PTR_W:0]     next_cnt;
  logic               done;
  logic               next_done;

  always_comb begin
    next_busy = busy;
    next_cnt  = cnt;
    next_done = 1'b0;
    if (tb.load_start && !busy) begin
      next_busy = 1'b1;
      next_cnt  = '0;
    end else if (busy) begin
      next_cnt = cnt + 1'b1;
      if (cnt == (PTR_W+1)'(DEPTH - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy <= 1'b0;
      cnt  <= '0;
      done <= 1'b0;
    end else if (ce_i) begin
      busy <= next_busy;
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

  // reset table: entry i names function i mod count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        shadow[i]  <= ENTRY_W'(i % N_FUNC);
        working[i] <= ENTRY_W'(i % N_FUNC);
      end
    end else if (ce_i) begin
      if (tb.wr_en)
        shadow[tb.wr_addr] <= tb.wr_data;
      // working copy changes only during a load
      if (busy)
        working[cnt[PTR_W-1:0]] <= shadow[cnt[PTR_W-1:0]];
    end
  end

  assign tb.load_done = done;
  assign tb.rd_data   = working[tb.rd_addr];
endmodule // mfca_table

// *** mfca_arbiter.sv ***
/*
  egress function arbiter for one channel of a multi-function device,
  driven by a phase table in weighted or time-based round robin order.
  assumes request bits are on this clock and a grant is taken in the
  cycle it shows; tick comes from local timeslot logic on this clock.
*/
// How it works
// - a write to any table entry sets the coherency flag, bit 0
// - coherency flag clears when the requested table load finishes
// - coherency flag resets to zero; status flags are read only
// - negotiating flag, bit 1, is high while enable/disable negotiates
// - default channel: negotiating flag shows flow control init in progress
// - table present only if advertised, used only when selected
// - table is one arbitration period, each entry one phase
// - entry width covers all functions plus one unused value
// - with routing-ID interpretation, entries are four or eight bits
// - grouping: entry picks a group, fair choice inside the group
// - no grouping: entry matches functions modulo 8 or modulo 128
// - several matches picked round robin so none starves
// - weighted mode: serve one transaction then advance at once
// - weighted mode: empty phase is skipped directly
// - timed mode: one transaction per phase, advance on timeslot
// - timed mode: idle slot for missing or empty function
// - entry width from entry-size field, length from selection
// - lengths: 001b 32, 010b 64, 011b/100b 128, 101b 256
// - reset table gives each active function at least one entry
// - writing one to load bit starts a load; reads back zero
// - selection field in bits 19:17 picks an advertised scheme
// - bit 31 enables channel; hardwired one for default channel
`timescale 1ns/10ps
`include "mfca_defines.svh"
module mfca_arbiter #(
  parameter int   N_FUNC      = 8,
  parameter int   ENTRY_W     = 4,
  parameter int   PTR_W       = 8,
  parameter int   DEPTH       = 256,
  parameter bit   DEFAULT_CH  = 1'b1,
  parameter bit   GROUPS      = 1'b0,
  parameter logic [5:0] CAP_SCHEMES = 6'h3E
) (
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RSTN_I,
  input  wire logic                   CE_I,
  input  wire logic                   CTL_WR_I,
  input  wire logic [31:0]            CTL_WDATA_I,
  input  wire logic                   TBL_WR_I,
  input  wire logic [PTR_W-1:0]       TBL_ADDR_I,
  input  wire logic [ENTRY_W-1:0]     TBL_WDATA_I,
  input  wire logic                   FC_INIT_BUSY_I,
  input  wire logic                   NEG_BUSY_I,
  input  wire logic                   SLOT_TICK_I,
  input  wire logic [N_FUNC-1:0]      FUNC_REQ_I,
  input  wire logic [N_FUNC-1:0]      FUNC_GROUP_I,
  input  wire logic                   EGRESS_READY_I,
  output logic [31:0]                 CTL_RDATA_O,
  output logic [`MFCA_STS_WIDTH-1:0]  STATUS_O,
  output logic [N_FUNC-1:0]           GRANT_O,
  output logic [PTR_W-1:0]            PHASE_O
);
  import mfca_pkg::*;
  localparam int FN_W = (N_FUNC > 1) ? $clog2(N_FUNC) : 1;

  mfca_table_if #(.ENTRY_W(ENTRY_W), .PTR_W(PTR_W)) tb ();

  mfca_table #(
    .ENTRY_W (ENTRY_W),
    .PTR_W   (PTR_W),
    .DEPTH   (DEPTH),
    .N_FUNC  (N_FUNC)
  ) u_table (
    .clk_i   (CLK_SYS_I),
    .rstn_i  (RSTN_I),
    .ce_i    (CE_I),
    .tb      (tb)
  );

  // control and status state
  mfca_sel_t                sel;
  mfca_sel_t                next_sel;
  logic                     ch_on;
  logic                     next_ch_on;
  logic                     tbl_dirty;
  logic                     next_tbl_dirty;
  logic                     load_req;
  logic                     next_load_req;
  logic                     loading;
  logic                     next_loading;
  logic                     neg_q1;
  logic                     neg_q2;
  logic [`MFCA_STS_WIDTH-1:0] next_status;
  logic [31:0]              next_rdata;

  // arbitration state
  mfca_state_t              state;
  mfca_state_t              next_state;
  logic [PTR_W-1:0]         phase;
  logic [PTR_W-1:0]         next_phase;
  logic [N_FUNC-1:0]        grant;
  logic [N_FUNC-1:0]        next_grant;
  logic [FN_W-1:0]          rr_last;
  logic [FN_W-1:0]          next_rr_last;
  logic                     slot_used;
  logic                     next_slot_used;

  logic [8:0]               tbl_len;
  logic                     timed;
  logic                     tbl_used;
  logic [N_FUNC-1:0]        match;
  logic [N_FUNC-1:0]        ready_set;
  logic [N_FUNC-1:0]        pick;
  logic [FN_W-1:0]          pick_idx;
  logic                     ph_last;

  always_comb begin
    unique case (sel)
      `MFCA_SEL_WRR32:   tbl_len = `MFCA_LEN_32;
      `MFCA_SEL_WRR64:   tbl_len = `MFCA_LEN_64;
      `MFCA_SEL_WRR128,
      `MFCA_SEL_TWRR128: tbl_len = `MFCA_LEN_128;
      default:           tbl_len = `MFCA_LEN_256;
    endcase
    timed    = (sel == `MFCA_SEL_TWRR128) || (sel == `MFCA_SEL_TWRR256);
    // table only drives arbitration for an advertised table scheme
    tbl_used = (sel >= `MFCA_SEL_WRR32) && (sel <= `MFCA_SEL_TWRR256) &&
               CAP_SCHEMES[sel];
    ph_last  = ({1'b0, phase} == tbl_len - 9'h001) ||
               (phase == PTR_W'(DEPTH - 1));
  end

  // entry matches by group, or by function number modulo half the entry range
  always_comb begin
    match = '0;
    for (int f = 0; f < N_FUNC; f++) begin
      if (GROUPS)
        match[f] = (ENTRY_W'(FUNC_GROUP_I[f]) == tb.rd_data);
      else
        match[f] = (ENTRY_W'(f % (1 << (ENTRY_W - 1 + (ENTRY_W == 4 ? 0 : 0))))
                    == tb.rd_data) || (ENTRY_W'(f) == tb.rd_data);
    end
    ready_set = match & FUNC_REQ_I;
  end

  // rotate from last winner among matched requesters
  always_comb begin
    int idx;
    idx      = 0;
    pick     = '0;
    pick_idx = rr_last;
    for (int k = N_FUNC; k >= 1; k--) begin
      idx = (int'(rr_last) + k) % N_FUNC;
      if (ready_set[idx]) begin
        pick     = '0;
        pick[idx] = 1'b1;
        pick_idx = FN_W'(idx);
      end
    end
  end

  // control register, status and load handshake
  always_comb begin
    next_sel       = sel;
    next_ch_on     = ch_on;
    next_load_req  = 1'b0;
    next_loading   = loading;
    next_tbl_dirty = tbl_dirty;
    if (CTL_WR_I) begin
      next_sel = CTL_WDATA_I[`MFCA_CTL_SEL_HI:`MFCA_CTL_SEL_LO];
      next_ch_on = DEFAULT_CH ? 1'b1 : CTL_WDATA_I[`MFCA_CTL_ON_BIT];
      next_load_req = CTL_WDATA_I[`MFCA_CTL_LOAD_BIT];
    end
    if (tb.load_done)
      next_loading = 1'b0;
    if (load_req)
      next_loading = 1'b1;
    if (tb.load_done && !TBL_WR_I)
      next_tbl_dirty = 1'b0;
    if (TBL_WR_I)
      next_tbl_dirty = 1'b1;
    next_status = `MFCA_STS_RESET;
    next_status[`MFCA_STS_TABLE_BIT] = next_tbl_dirty;
    next_status[`MFCA_STS_NEG_BIT] = neg_q2;
    next_rdata = '0;
    next_rdata[`MFCA_CTL_SEL_HI:`MFCA_CTL_SEL_LO] = next_sel;
    next_rdata[`MFCA_CTL_ON_BIT] = next_ch_on;
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sel         <= `MFCA_SEL_WRR32;
      ch_on       <= DEFAULT_CH;
      load_req    <= 1'b0;
      loading     <= 1'b0;
      tbl_dirty   <= 1'b0;
      neg_q1      <= 1'b0;
      neg_q2      <= 1'b0;
      STATUS_O    <= `MFCA_STS_RESET;
      CTL_RDATA_O <= {DEFAULT_CH, 11'h000, `MFCA_SEL_WRR32, 17'h00000};
    end else if (CE_I) begin
      sel         <= next_sel;
      ch_on       <= next_ch_on;
      load_req    <= next_load_req;
      loading     <= next_loading;
      tbl_dirty   <= next_tbl_dirty;
      neg_q1      <= DEFAULT_CH ? FC_INIT_BUSY_I : NEG_BUSY_I;
      neg_q2      <= neg_q1;
      STATUS_O    <= next_status;
      CTL_RDATA_O <= next_rdata; // load bit reads zero
    end
  end

  // phase walk
  always_comb begin
    next_state     = state;
    next_phase     = phase;
    next_grant     = '0;
    next_rr_last   = rr_last;
    next_slot_used = slot_used;
    if (SLOT_TICK_I)
      next_slot_used = 1'b0;
    unique case (state)
      MFCA_IDLE: begin
        if (ch_on && tbl_used && !neg_q2)
          next_state = MFCA_LOOK;
      end
      MFCA_LOOK: begin
        if (!ch_on || !tbl_used) begin
          next_state = MFCA_IDLE;
        end else if (timed) begin
          if (SLOT_TICK_I) begin
            next_phase = ph_last ? `MFCA_ZERO_PTR : phase + `MFCA_ONE_PTR;
          end else if (!slot_used && |ready_set && EGRESS_READY_I) begin
            next_grant     = pick;
            next_rr_last   = pick_idx;
            next_slot_used = 1'b1;
            next_state     = MFCA_GRANT;
          end // empty or missing function leaves the slot idle
        end else if (|ready_set) begin
          if (EGRESS_READY_I) begin
            next_grant   = pick;
            next_rr_last = pick_idx;
            next_state   = MFCA_GRANT;
          end
        end else begin
          next_phase = ph_last ? `MFCA_ZERO_PTR : phase + `MFCA_ONE_PTR;
        end
      end
      MFCA_GRANT: begin
        next_state = MFCA_LOOK;
        if (!timed)
          next_phase = ph_last ? `MFCA_ZERO_PTR : phase + `MFCA_ONE_PTR;
        else if (SLOT_TICK_I)
          next_phase = ph_last ? `MFCA_ZERO_PTR : phase + `MFCA_ONE_PTR;
      end
      MFCA_LOAD: begin
        next_state = MFCA_IDLE;
      end
    endcase
    if (!timed && ph_last && state == MFCA_IDLE)
      next_phase = `MFCA_ZERO_PTR;
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state     <= MFCA_IDLE;
      phase     <= `MFCA_ZERO_PTR;
      rr_last   <= '0;
      slot_used <= 1'b0;
      GRANT_O   <= '0;
      PHASE_O   <= `MFCA_ZERO_PTR;
    end else if (CE_I) begin
      state     <= next_state;
      phase     <= next_phase;
      rr_last   <= next_rr_last;
      slot_used <= next_slot_used;
      GRANT_O   <= next_grant;
      PHASE_O   <= next_phase;
    end
  end

  assign grant         = GRANT_O;
  assign tb.wr_en      = TBL_WR_I && CE_I;
  assign tb.wr_addr    = TBL_ADDR_I;
  assign tb.wr_data    = TBL_WDATA_I;
  assign tb.load_start = load_req && CE_I;
  assign tb.rd_addr    = phase;
endmodule // mfca_arbiter

// *** mfca_arbiter_props.sv ***
/*
  port-level checker of the function arbiter.
  assumes a bind onto mfca_arbiter, one clock, core enable held high.
*/
`timescale 1ns/10ps
module mfca_arbiter_props #(
  parameter int N_FUNC = 8,
  parameter int PTR_W  = 8,
  parameter int DEPTH  = 256
) (
  input wire logic              CLK_SYS_I,
  input wire logic              RSTN_I,
  input wire logic              CE_I,
  input wire logic              CTL_WR_I,
  input wire logic [31:0]       CTL_WDATA_I,
  input wire logic              TBL_WR_I,
  input wire logic              FC_INIT_BUSY_I,
  input wire logic [N_FUNC-1:0] FUNC_REQ_I,
  input wire logic [31:0]       CTL_RDATA_O,
  input wire logic [15:0]       STATUS_O,
  input wire logic [N_FUNC-1:0] GRANT_O,
  input wire logic [PTR_W-1:0]  PHASE_O
);
  localparam int LOAD_MIN = DEPTH + 1;
  localparam int LOAD_MAX = DEPTH + 2;
  wire [2:0] sel = CTL_RDATA_O[19:17];
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_load_req;
    CE_I && CTL_WR_I && CTL_WDATA_I[16] && !TBL_WR_I ##1 STATUS_O[0];
  endsequence
  sequence s_grant;
    CE_I && (GRANT_O != '0);
  endsequence
  chk_dirty_set: assert property (CE_I && TBL_WR_I |=> STATUS_O[0])
    else $error("table write left dirty flag clear");
  chk_dirty_clear: assert property (s_load_req |-> ##[LOAD_MIN:LOAD_MAX] $fell(STATUS_O[0]))
    else $error("dirty flag not cleared at end of load");
  chk_spare_zero: assert property (STATUS_O[15:2] == '0)
    else $error("spare status bits set");
  chk_load_reads_zero: assert property (!CTL_RDATA_O[16])
    else $error("load bit read back as one");
  chk_grant_onehot: assert property ($onehot0(GRANT_O))
    else $error("grant to several functions");
  chk_grant_spacing: assert property (s_grant |=> GRANT_O == '0)
    else $error("grants in adjacent cycles");
  chk_grant_needs_req: assert property (s_grant |-> (GRANT_O & $past(FUNC_REQ_I)) == GRANT_O)
    else $error("grant without request");
  chk_phase_step: assert property (s_grant and (sel == 3'h1) |=> int'(PHASE_O) == (int'($past(PHASE_O)) + 1) % 32)
    else $error("phase did not step after grant");
  chk_refused_sel: assert property ((sel == 3'h0) [*2] |-> GRANT_O == '0)
    else $error("grant under unadvertised select");
  chk_neg_rise: assert property ($rose(FC_INIT_BUSY_I) |-> ##[1:4] STATUS_O[1])
    else $error("negotiating flag not raised");
  chk_neg_fall: assert property ($fell(FC_INIT_BUSY_I) |-> ##[1:4] !STATUS_O[1])
    else $error("negotiating flag not cleared");
endmodule // mfca_arbiter_props

bind mfca_arbiter mfca_arbiter_props #(.N_FUNC(N_FUNC), .PTR_W(PTR_W), .DEPTH(DEPTH))
  mfca_arbiter_props_inst (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
    .CTL_WR_I(CTL_WR_I), .CTL_WDATA_I(CTL_WDATA_I), .TBL_WR_I(TBL_WR_I),
    .FC_INIT_BUSY_I(FC_INIT_BUSY_I), .FUNC_REQ_I(FUNC_REQ_I), .CTL_RDATA_O(CTL_RDATA_O),
    .STATUS_O(STATUS_O), .GRANT_O(GRANT_O), .PHASE_O(PHASE_O));

// *** mfca_func_src.sv ***
/*
  model of the function queues and the egress port.
  assumes the arbiter clock; slow_i makes the egress ready alternate.
*/
`timescale 1ns/10ps
module mfca_func_src #(parameter int N_FUNC = 8) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic [N_FUNC-1:0] want_i,
  input  wire logic              slow_i,
  input  wire logic [N_FUNC-1:0] grant_i,
  output logic [N_FUNC-1:0]      req_o,
  output logic                   ready_o
);
  logic [N_FUNC-1:0] next_req;
  logic              next_ready;
  always_comb begin
    // one transaction leaves per grant, refill a cycle later
    next_req   = want_i & ~(req_o & grant_i);
    next_ready = slow_i ? ~ready_o : 1'b1;
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_o   <= '0;
      ready_o <= 1'b0;
    end else begin
      req_o   <= next_req;
      ready_o <= next_ready;
    end
  end
endmodule // mfca_func_src

// *** test_mfca_arbiter.sv ***
/*
  bench of the function arbiter: reset, negotiation, round robin,
  table load, timed slots, selection.
  assumes the source model and the bound checker are compiled.
*/
`timescale 1ns/10ps
module test_mfca_arbiter;
  localparam int NF = 8;
  logic        clk_sys   = 1'b0;
  logic        rstn      = 1'b0;
  logic        ctl_wr    = 1'b0;
  logic        tbl_wr    = 1'b0;
  logic        fc_busy   = 1'b0;
  logic        tick      = 1'b0;
  logic        slow      = 1'b0;
  logic [31:0] ctl_wdata = '0;
  logic [7:0]  tbl_addr  = '0;
  logic [3:0]  tbl_wdata = '0;
  logic [7:0]  want      = '0;
  logic        ready;
  logic [7:0]  req, grant, phase;
  logic [31:0] ctl_rdata;
  logic [15:0] status;
  int          failures    = 0;
  int          comparisons = 0;
  int          hits [NF];
  int          wraps;

  mfca_arbiter mfca_arbiter_inst (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .CE_I(1'b1),
    .CTL_WR_I(ctl_wr), .CTL_WDATA_I(ctl_wdata), .TBL_WR_I(tbl_wr), .TBL_ADDR_I(tbl_addr),
    .TBL_WDATA_I(tbl_wdata), .FC_INIT_BUSY_I(fc_busy), .NEG_BUSY_I(1'b0),
    .SLOT_TICK_I(tick), .FUNC_REQ_I(req), .FUNC_GROUP_I(8'h00), .EGRESS_READY_I(ready),
    .CTL_RDATA_O(ctl_rdata), .STATUS_O(status), .GRANT_O(grant), .PHASE_O(phase));
  mfca_func_src mfca_func_src_inst (.clk_i(clk_sys), .rstn_i(rstn), .want_i(want),
    .slow_i(slow), .grant_i(grant), .req_o(req), .ready_o(ready));

  always #2.5 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_sts(input int b, input logic v, input int lim);
    for (int i = 0; i < lim && status[b] !== v; i++) cyc();
    check(status[b], v);
    if (status[b] !== v) complete_run();
  endtask
  task automatic ctl(input logic [31:0] w);
    @(posedge clk_sys);
    ctl_wr <= 1'b1;
    ctl_wdata <= w;
    @(posedge clk_sys);
    ctl_wr <= 1'b0;
  endtask
  task automatic fill(input int n, input logic [3:0] v);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      tbl_wr <= 1'b1;
      tbl_addr <= 8'(i);
      tbl_wdata <= v;
    end
    @(posedge clk_sys);
    tbl_wr <= 1'b0;
  endtask
  task automatic count(input int n);
    logic [7:0] last;
    foreach (hits[f]) hits[f] = 0;
    wraps = 0;
    repeat (n) begin
      last = phase;
      cyc();
      if (phase === 8'h00 && last === 8'h1F) wraps++;
      foreach (hits[f]) if (grant[f] === 1'b1) hits[f]++;
    end
  endtask
  task automatic traffic(input logic [7:0] w, input logic s, input int n);
    @(posedge clk_sys);
    want <= w;
    slow <= s;
    repeat (4) cyc();
    count(n);
  endtask
  function automatic int others(input int f);
    others = 0;
    foreach (hits[i]) others += (i != f) ? hits[i] : 0;
  endfunction
  task automatic slots(input int f, input int exp);
    logic [7:0] p;
    for (int s = 0; s < 6; s++) begin
      @(posedge clk_sys);
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
      #1;
      p = phase;
      count(14);
      if (s > 0) begin
        check(hits[f], exp);
        check(phase, p);
      end
    end
  endtask

  task automatic t_reset;
    check(status, 16'h0000);
    check(ctl_rdata, 32'h8002_0000);
    $display("reset test done");
  endtask
  task automatic t_neg;
    @(posedge clk_sys);
    fc_busy <= 1'b1;
    wait_sts(1, 1'b1, 8);
    repeat (20) cyc();
    check(status[1], 1'b1);
    @(posedge clk_sys);
    fc_busy <= 1'b0;
    wait_sts(1, 1'b0, 8);
    $display("negotiation test done");
  endtask
  task automatic t_wrr;
    traffic(8'hFF, 1'b1, 400);
    foreach (hits[f]) check(hits[f] > 0, 1'b1);
    check(wraps > 0, 1'b1);
    traffic(8'h08, 1'b0, 200);
    check(hits[3] >= 4, 1'b1);
    check(others(3), 0);
    $display("round robin test done");
  endtask
  task automatic t_load;
    fill(32, 4'h5);
    cyc();
    check(status[0], 1'b1);
    traffic(8'h02, 1'b0, 200);
    check(hits[1] > 0, 1'b1);
    ctl(32'h8003_0000);
    wait_sts(0, 1'b0, 270);
    check(ctl_rdata[16], 1'b0);
    traffic(8'h22, 1'b0, 200);
    check(hits[1], 0);
    check(hits[5] > 0, 1'b1);
    $display("table load test done");
  endtask
  task automatic t_timed;
    fill(128, 4'h5);
    ctl(32'h8009_0000);
    wait_sts(0, 1'b0, 270);
    traffic(8'h20, 1'b0, 1);
    slots(5, 1);
    traffic(8'h02, 1'b0, 1);
    slots(1, 0);
    $display("timed test done");
  endtask
  task automatic t_select;
    ctl(32'h0000_0000);
    cyc();
    check(ctl_rdata[31], 1'b1);
    traffic(8'hFF, 1'b0, 100);
    check(others(NF), 0);
    for (int s = 1; s < 6; s++) begin
      ctl(32'(s) << 17);
      cyc();
      check(ctl_rdata[19:17], s);
    end
    $display("select test done");
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    cyc();
    t_reset();
    t_neg();
    t_wrr();
    t_load();
    t_timed();
    t_select();
    complete_run();
  end
endmodule // test_mfca_arbiter
